// file: hdl/pirf_flag_block.sv
// Peripheral interrupt flag register with APB access and interrupt output
//
// The APB slave port was decided locally.
`timescale 1ns/100ps
module pirf_flag_block
#(
    parameter int ADDR_W = pirf_pkg::ADDR_W
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // APB slave
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pirf_pkg::DATA_W-1:0] pwdata,
    output logic [pirf_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Peripheral event pulses, same clock
    input wire pirf_pkg::pirf_events_t events,
    // To enable and vectoring logic
    output logic [pirf_pkg::REG_W-1:0] flags,
    output logic irq
);

    // Address width must match the package offsets
    if (ADDR_W != pirf_pkg::ADDR_W)
    begin : g_badAddr
        $error("pirf_flag_block: ADDR_W must equal the package width");
    end

    // Address decode shared by setup read and access hit
    function automatic logic [3:0] decode(input logic [ADDR_W-1:0] a);
        logic [3:0] hit;
        hit = 4'h0;
        if (a == pirf_pkg::OFF_FLAGS)
            hit = 4'h1;
        else if (a == pirf_pkg::OFF_STATUS)
            hit = 4'h2;
        else if (a == pirf_pkg::OFF_MASK)
            hit = 4'h4;
        else if (a == pirf_pkg::OFF_CTRL)
            hit = 4'h8;
        return hit;
    endfunction : decode

    // Bus front end signals
    logic setupCycle;
    pirf_pkg::pirf_apb_req_t reqNow;
    pirf_pkg::pirf_apb_req_t req;
    logic wrDone;
    logic rdDone;
    // Decoded selects in setup and access phases
    logic [3:0] hitNow;
    logic [3:0] hitAcc;
    logic addrHit;

    // Register values
    logic [pirf_pkg::REG_W-1:0] flagVal;
    logic [pirf_pkg::REG_W-1:0] statusVal;
    logic [pirf_pkg::REG_W-1:0] mask_reg;
    logic [pirf_pkg::REG_W-1:0] mask_next;
    pirf_pkg::pirf_cc_mode_t mode_reg;
    pirf_pkg::pirf_cc_mode_t mode_next;
    // Hardware set vector for this cycle
    logic [pirf_pkg::REG_W-1:0] setVec;
    // Read path
    logic [pirf_pkg::REG_W-1:0] readMux;
    logic [pirf_pkg::DATA_W-1:0] prdata_reg;
    // Status bits that the pending read returned
    logic [pirf_pkg::REG_W-1:0] statusSnap_reg;
    // Loads into the sticky vectors
    logic flagLoad;
    logic statusLoad;
    logic [pirf_pkg::REG_W-1:0] statusClr;
    logic [1:0] modeField;

    // APB phase logic and request latch
    pirf_apb_if u_apb
    (
        .clock(clock),
        .srst(srst),
        .paddr(paddr),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .pwdata(pwdata),
        .addrHit(addrHit),
        .pready(pready),
        .pslverr(pslverr),
        .setupCycle(setupCycle),
        .reqNow(reqNow),
        .req(req),
        .wrDone(wrDone),
        .rdDone(rdDone)
    );

    // Decode the live address for the read and the latched one for effects
    assign hitNow = decode(reqNow.addr);
    assign hitAcc = decode(req.addr);
    assign addrHit = |hitAcc;

    // Event to flag mapping; enables and the global enable are not consulted
    // because they live outside this block
    always_comb
    begin
        setVec = '0;
        setVec[pirf_pkg::BIT_CONV] = events.convDone;
        setVec[pirf_pkg::BIT_SERIAL] = events.serialTxDone | events.serialRxDone;
        // Bit 2 source follows the unit mode; pulse-width mode feeds nothing
        case (mode_reg)
            pirf_pkg::PIRF_CC_CAPTURE: setVec[pirf_pkg::BIT_CC] = events.captureEvent;
            pirf_pkg::PIRF_CC_COMPARE: setVec[pirf_pkg::BIT_CC] = events.compareMatch;
            default: setVec[pirf_pkg::BIT_CC] = 1'b0;
        endcase
        setVec[pirf_pkg::BIT_T2] = events.timer2Match;
        setVec[pirf_pkg::BIT_T1] = events.timer1Overflow;
    end

    // Flag register: software may write ones or zeros, events win
    assign flagLoad = wrDone & hitAcc[0];

    // Flags hold until written; hardware never clears them itself
    pirf_sticky
    #(
        .WIDTH(pirf_pkg::REG_W),
        .IMPL(pirf_pkg::IMPL_MASK),
        .RST(pirf_pkg::FLAGS_RST)
    )
    u_flags
    (
        .clock(clock),
        .srst(srst),
        .setVec(setVec),
        .loadEn(flagLoad),
        .loadVal(req.wdata[pirf_pkg::REG_W-1:0]),
        .value(flagVal)
    );

    // Interrupt status: read clears only the bits the read returned, so an
    // event landing between setup and access is kept for the next read
    assign statusLoad = rdDone & hitAcc[1];
    assign statusClr = statusVal & ~statusSnap_reg;

    pirf_sticky
    #(
        .WIDTH(pirf_pkg::REG_W),
        .IMPL(pirf_pkg::IMPL_MASK),
        .RST(pirf_pkg::STATUS_RST)
    )
    u_status
    (
        .clock(clock),
        .srst(srst),
        .setVec(setVec),
        .loadEn(statusLoad),
        .loadVal(statusClr),
        .value(statusVal)
    );

    // Mask and mode next values
    assign mask_next = (wrDone & hitAcc[2]) ? (req.wdata[pirf_pkg::REG_W-1:0] & pirf_pkg::IMPL_MASK) : mask_reg;
    assign modeField = req.wdata[pirf_pkg::CTRL_MODE_LSB +: pirf_pkg::CTRL_MODE_W];
    // Undefined mode code keeps the previous mode
    assign mode_next = (wrDone & hitAcc[3] & (modeField <= 2'h2)) ? pirf_pkg::pirf_cc_mode_t'(modeField) : mode_reg;

    // Mask and mode storage
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            mask_reg <= pirf_pkg::MASK_RST;
            mode_reg <= pirf_pkg::CTRL_MODE_RST;
        end
        else
        begin
            mask_reg <= mask_next;
            mode_reg <= mode_next;
        end
    end

    // Read selection; unimplemented bits are zero in every register
    assign readMux = hitNow[0] ? flagVal :
                     hitNow[1] ? statusVal :
                     hitNow[2] ? mask_reg :
                     hitNow[3] ? {6'h00, mode_reg} : 8'h00;

    // Read data is registered in the setup cycle and held through access
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            prdata_reg <= '0;
            statusSnap_reg <= '0;
        end
        else if (setupCycle)
        begin
            prdata_reg <= {24'h000000, readMux};
            statusSnap_reg <= (hitNow[1] & ~reqNow.write) ? statusVal : 8'h00;
        end
    end

    // Outputs
    assign prdata = prdata_reg;
    assign flags = flagVal;
    // Level interrupt while any unmasked status bit is set
    assign irq = |(statusVal & mask_reg);

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    // Software write to the flag register in this cycle; the hold checks
    // below must exempt it, because a write of zero is a legal clear
    logic flagWr;
    assign flagWr = flagLoad;

    property p_anySet;
        (setVec != 8'h00) |=> ((flags & $past(setVec)) == $past(setVec));
    endproperty
    a_anySet: assert property (p_anySet) else $error("event did not set its flag");

    property p_unimpl;
        (flags[7] == 1'b0) && (flags[5:4] == 2'b00);
    endproperty
    a_unimpl: assert property (p_unimpl) else $error("unimplemented flag bit set");

    property p_unimplRead;
        (pready && hitAcc[0]) |-> (prdata[7] == 1'b0) && (prdata[5:4] == 2'b00) && (prdata[31:8] == 24'h000000);
    endproperty
    a_unimplRead: assert property (p_unimplRead) else $error("unimplemented bit read non-zero");

    property p_conv;
        events.convDone |=> flags[pirf_pkg::BIT_CONV];
    endproperty
    a_conv: assert property (p_conv) else $error("conversion flag not set");

    property p_serial;
        (events.serialTxDone || events.serialRxDone) |=> flags[pirf_pkg::BIT_SERIAL] ##1 1'b1;
    endproperty
    a_serial: assert property (p_serial) else $error("serial flag not set");

    // Serial flag is only ever cleared by software, never by hardware
    property p_serialHold;
        (flags[pirf_pkg::BIT_SERIAL] && !flagWr) |=> flags[pirf_pkg::BIT_SERIAL];
    endproperty
    a_serialHold: assert property (p_serialHold) else $error("serial flag dropped by hardware");

    property p_capture;
        (mode_reg == pirf_pkg::PIRF_CC_CAPTURE && events.captureEvent) |=> flags[pirf_pkg::BIT_CC];
    endproperty
    a_capture: assert property (p_capture) else $error("capture did not set flag");

    property p_pwmQuiet;
        (mode_reg == pirf_pkg::PIRF_CC_PWM && !flagWr) |=> !$rose(flags[pirf_pkg::BIT_CC]);
    endproperty
    a_pwmQuiet: assert property (p_pwmQuiet) else $error("flag rose in pulse-width mode");

    property p_compare;
        (mode_reg == pirf_pkg::PIRF_CC_COMPARE && events.compareMatch) |=> flags[pirf_pkg::BIT_CC];
    endproperty
    a_compare: assert property (p_compare) else $error("compare did not set flag");

    property p_timer2Hold;
        (flags[pirf_pkg::BIT_T2] && !flagWr) |=> flags[pirf_pkg::BIT_T2];
    endproperty
    a_timer2Hold: assert property (p_timer2Hold) else $error("timer two flag dropped");

    property p_timer1;
        events.timer1Overflow |=> flags[pirf_pkg::BIT_T1];
    endproperty
    a_timer1: assert property (p_timer1) else $error("timer one flag not set");

    property p_writeValue;
        (flagWr && setVec == 8'h00) |=> (flags == ($past(req.wdata[7:0]) & pirf_pkg::IMPL_MASK));
    endproperty
    a_writeValue: assert property (p_writeValue) else $error("flag write not stored");

    property p_setWins;
        (flagWr && events.timer1Overflow) |=> flags[pirf_pkg::BIT_T1];
    endproperty
    a_setWins: assert property (p_setWins) else $error("write beat a hardware set");

    // Any unmasked event must raise the interrupt on the next cycle,
    // unless a mask write lands at the same edge
    property p_irqLevel;
        (((setVec & mask_reg) != 8'h00) && !(wrDone && hitAcc[2])) |=> irq;
    endproperty
    a_irqLevel: assert property (p_irqLevel) else $error("interrupt level wrong");

    // Status bits only fall through a status read; otherwise they are kept
    property p_statusKeep;
        ((statusVal != 8'h00) && !statusLoad) |=> ((statusVal & $past(statusVal)) == $past(statusVal));
    endproperty
    a_statusKeep: assert property (p_statusKeep) else $error("status bit lost without a read");

    // Main scenarios
    c_setAndWrite: cover property (flagWr && setVec != 8'h00);
    c_statusRead: cover property (statusLoad && statusVal != 8'h00);
    c_irqRise: cover property ($rose(irq));
    c_badAddr: cover property (pslverr);
    c_pwmEvent: cover property (mode_reg == pirf_pkg::PIRF_CC_PWM && events.compareMatch);

endmodule : pirf_flag_block

// file: hdl/pirf_pkg.sv
// Package of constants and types for the peripheral interrupt flag block
// Functional notes
// - Flags set regardless of enables or global enable
// - Bits 7, 5, 4 read zero, ignore writes
// - Bit 6 set on conversion complete
// - Bit 3 set on serial transmit or receive
// - Capture mode: bit 2 set on capture
// - Compare mode sets bit 2; pulse-width mode unused
// - Bit 1 set on timer two period match
// - Bit 0 set on timer one overflow
package pirf_pkg;

    // Bus geometry
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int REG_W = 8;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFF_FLAGS = 8'h0c;
    localparam logic [ADDR_W-1:0] OFF_STATUS = 8'h10;
    localparam logic [ADDR_W-1:0] OFF_MASK = 8'h14;
    localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h18;

    // Flag bit positions, shared by flags, status and mask
    localparam int BIT_CONV = 6;
    localparam int BIT_SERIAL = 3;
    localparam int BIT_CC = 2;
    localparam int BIT_T2 = 1;
    localparam int BIT_T1 = 0;

    // Implemented bits and reset values
    localparam logic [REG_W-1:0] IMPL_MASK = 8'h4f;
    localparam logic [REG_W-1:0] FLAGS_RST = 8'h00;
    localparam logic [REG_W-1:0] STATUS_RST = 8'h00;
    localparam logic [REG_W-1:0] MASK_RST = 8'h00;

    // Control register: capture/compare unit mode field
    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_W = 2;

    // Operating modes of the capture/compare unit
    typedef enum logic [1:0] {
        PIRF_CC_CAPTURE,
        PIRF_CC_COMPARE,
        PIRF_CC_PWM
    } pirf_cc_mode_t;

    // Mode after reset
    localparam pirf_cc_mode_t CTRL_MODE_RST = PIRF_CC_CAPTURE;

    // One APB request as latched in its setup cycle
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic write;
        logic [DATA_W-1:0] wdata;
    } pirf_apb_req_t;

    // One-cycle event pulses from the peripherals
    typedef struct packed {
        logic convDone;
        logic serialTxDone;
        logic serialRxDone;
        logic captureEvent;
        logic compareMatch;
        logic timer2Match;
        logic timer1Overflow;
    } pirf_events_t;

endpackage : pirf_pkg

// file: hdl/pirf_apb_if.sv
// APB slave front end: phase tracking, request latch and strobes
`timescale 1ns/100ps
module pirf_apb_if
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // APB slave side
    input wire logic [pirf_pkg::ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pirf_pkg::DATA_W-1:0] pwdata,
    input wire logic addrHit,
    output logic pready,
    output logic pslverr,
    // Towards the register file
    output logic setupCycle,
    output pirf_pkg::pirf_apb_req_t reqNow,
    output pirf_pkg::pirf_apb_req_t req,
    output logic wrDone,
    output logic rdDone
);

    // Request latched in setup so the access phase sees stable fields
    pirf_pkg::pirf_apb_req_t req_reg;
    // Access phase currently open
    logic access;

    assign setupCycle = psel & ~penable;
    assign access = psel & penable;
    assign reqNow = '{addr: paddr, write: pwrite, wdata: pwdata};

    // Zero-wait slave: read data was prepared during setup
    assign pready = access;
    // Unmapped offsets answer with an error and no effect
    assign pslverr = access & ~addrHit;
    assign wrDone = access & pwrite & addrHit;
    assign rdDone = access & ~pwrite & addrHit;
    assign req = req_reg;

    // Capture the request at the setup edge
    always_ff @(posedge clock)
    begin
        if (srst)
            req_reg <= '0;
        else if (setupCycle)
            req_reg <= reqNow;
    end

endmodule : pirf_apb_if

// file: hdl/pirf_sticky.sv
// Vector of sticky bits where a hardware set wins over a load
`timescale 1ns/100ps
module pirf_sticky
#(
    parameter int WIDTH = 8,
    parameter logic [WIDTH-1:0] IMPL = '1,
    parameter logic [WIDTH-1:0] RST = '0
)
(
    // Clock and reset
    input wire logic clock,
    input wire logic srst,
    // Update controls
    input wire logic [WIDTH-1:0] setVec,
    input wire logic loadEn,
    input wire logic [WIDTH-1:0] loadVal,
    // Stored value
    output logic [WIDTH-1:0] value
);

    logic [WIDTH-1:0] bits_reg;
    logic [WIDTH-1:0] bits_next;

    // Width must hold at least one bit
    if (WIDTH < 1)
    begin : g_badWidth
        $error("pirf_sticky: WIDTH must be at least 1");
    end

    // Set is ORed after the load so a same-cycle event is never lost;
    // unimplemented bits are forced low on every path
    assign bits_next = (setVec | (loadEn ? loadVal : bits_reg)) & IMPL;
    assign value = bits_reg;

    // Storage
    always_ff @(posedge clock)
    begin
        if (srst)
            bits_reg <= RST & IMPL;
        else
            bits_reg <= bits_next;
    end

endmodule : pirf_sticky

// file: sim/pirf_periph_model.sv
// Peripheral event source model that drives one-cycle event pulses
`timescale 1ns/100ps
module pirf_periph_model
(
    // Clock
    input wire logic clock,
    // Event pulses towards the flag block
    output pirf_pkg::pirf_events_t events
);
    // No event pending at start
    initial events = '0;

    // Raise the given events for exactly one cycle; caller sits just after a rising edge
    task automatic fire(input pirf_pkg::pirf_events_t ev);
        events <= ev;
        @(posedge clock);
        // Real peripherals pulse once, so never leave a level behind
        events <= '0;
    endtask : fire
endmodule : pirf_periph_model

// file: sim/peripheral_irq_flag_register_test.sv
// Self-checking testbench of the peripheral interrupt flag block
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin compares++; if ((got) !== (exp)) begin error_cnt++; \
    $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module peripheral_irq_flag_register_test;
    // Clock, reset and APB master signals
    logic clock = 1'b0;
    logic srst = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    // Design outputs
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] flags;
    logic irq;
    pirf_pkg::pirf_events_t events;
    // Counters and read results
    int error_cnt = 0;
    int compares = 0;
    int cycles = 0;
    logic [31:0] rd;
    logic err;
    // Each single event except compare match, and the flag bit it must set
    logic [6:0] evTab [6] = '{7'h40, 7'h20, 7'h10, 7'h08, 7'h02, 7'h01};
    logic [7:0] expTab [6] = '{8'h40, 8'h08, 8'h08, 8'h04, 8'h02, 8'h01};

    // 200 MHz clock
    always #2.5 clock = ~clock;

    pirf_flag_block dut (.clock(clock), .srst(srst), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .events(events), .flags(flags), .irq(irq));
    pirf_periph_model model (.clock(clock), .events(events));

    // Verdict and end of run
    task automatic summarize();
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : summarize

    // Hang guard: the tests need fewer than 150 cycles
    always @(posedge clock)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            error_cnt++;
            summarize();
        end
    end

    // One APB transfer; request held until pready is seen high at a rising edge
    task automatic apb(input logic [7:0] a, input logic wr, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1)
            @(posedge clock);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Pulse events, let the flags settle, compare the flag output
    task automatic fireChk(input logic [6:0] ev, input logic [7:0] exp);
        @(posedge clock);
        model.fire(pirf_pkg::pirf_events_t'(ev));
        repeat (2) @(posedge clock);
        @(negedge clock);
        `CHK("flags", exp, flags)
    endtask : fireChk

    // Main sequence
    initial
    begin
        repeat (6) @(posedge clock);
        srst <= 1'b0;
        apb(pirf_pkg::OFF_FLAGS, 1'b0, 32'h0, rd, err);
        `CHK("flags reset", 32'h0, rd)
        apb(pirf_pkg::OFF_MASK, 1'b0, 32'h0, rd, err);
        `CHK("mask reset", 32'h0, rd)
        // Every source except compare match, with all interrupts masked off
        for (int i = 0; i < 6; i++)
        begin
            fireChk(evTab[i], expTab[i]);
            `CHK("irq masked", 1'b0, irq)
            apb(pirf_pkg::OFF_STATUS, 1'b0, 32'h0, rd, err);
            `CHK("status", {24'h0, expTab[i]}, rd)
            apb(pirf_pkg::OFF_FLAGS, 1'b1, 32'h0, rd, err);
            @(negedge clock);
            `CHK("flags cleared", 8'h00, flags)
        end
        // Unimplemented bits stay zero
        apb(pirf_pkg::OFF_FLAGS, 1'b1, 32'hffff_ffff, rd, err);
        apb(pirf_pkg::OFF_FLAGS, 1'b0, 32'h0, rd, err);
        `CHK("flags rw", 32'h4f, rd)
        `CHK("mapped err", 1'b0, err)
        apb(pirf_pkg::OFF_FLAGS, 1'b1, 32'h0, rd, err);
        // Status ignores writes; unmapped address errors
        apb(pirf_pkg::OFF_STATUS, 1'b1, 32'hff, rd, err);
        apb(pirf_pkg::OFF_STATUS, 1'b0, 32'h0, rd, err);
        `CHK("status write", 32'h0, rd)
        apb(8'h20, 1'b0, 32'h0, rd, err);
        `CHK("unmapped err", 1'b1, err)
        `CHK("unmapped data", 32'h0, rd)
        // Compare mode, pulse-width mode, then an ignored mode code
        apb(pirf_pkg::OFF_CTRL, 1'b1, 32'h1, rd, err);
        fireChk(7'h08, 8'h00);
        fireChk(7'h04, 8'h04);
        apb(pirf_pkg::OFF_CTRL, 1'b1, 32'h2, rd, err);
        apb(pirf_pkg::OFF_FLAGS, 1'b1, 32'h0, rd, err);
        fireChk(7'h0c, 8'h00);
        apb(pirf_pkg::OFF_CTRL, 1'b1, 32'h3, rd, err);
        fireChk(7'h04, 8'h00);
        apb(pirf_pkg::OFF_CTRL, 1'b0, 32'h0, rd, err);
        `CHK("mode kept", 32'h2, rd)
        // Stale status cleared before unmasking, as software should
        apb(pirf_pkg::OFF_STATUS, 1'b0, 32'h0, rd, err);
        apb(pirf_pkg::OFF_MASK, 1'b1, 32'h1, rd, err);
        fireChk(7'h02, 8'h02);
        `CHK("irq other bit", 1'b0, irq)
        fireChk(7'h01, 8'h03);
        `CHK("irq raised", 1'b1, irq)
        apb(pirf_pkg::OFF_STATUS, 1'b0, 32'h0, rd, err);
        `CHK("status read", 32'h3, rd)
        @(negedge clock);
        `CHK("irq cleared", 1'b0, irq)
        // Event in the same cycle as a write of zero
        fork
            apb(pirf_pkg::OFF_FLAGS, 1'b1, 32'h0, rd, err);
            begin
                repeat (2) @(posedge clock);
                model.fire(pirf_pkg::pirf_events_t'(7'h01));
            end
        join
        @(negedge clock);
        `CHK("set beats write", 8'h01, flags)
        `CHK("irq again", 1'b1, irq)
        // Reset in mid-run
        @(posedge clock);
        srst <= 1'b1;
        @(posedge clock);
        srst <= 1'b0;
        @(negedge clock);
        `CHK("flags after reset", 8'h00, flags)
        `CHK("irq after reset", 1'b0, irq)
        summarize();
    end
endmodule : peripheral_irq_flag_register_test
